// file: hdl/oipc_cfg.svh
/*
 * Constants of the oscillator pull-control serial front end: register
 * numbers, field positions, reset values and timing figures.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef OIPC_CFG_SVH
`define OIPC_CFG_SVH

// register numbers carried by the pointer byte
`define OIPC_REG_LSW 8'h00
`define OIPC_REG_MSW 8'h01
`define OIPC_REG_RANGE 8'h02

// field layout
`define OIPC_LSW_W 16
`define OIPC_MSW_W 10
`define OIPC_WORD_W 26
`define OIPC_OE_BIT 10
`define OIPC_RANGE_W 4

// reset values
`define OIPC_LSW_RST 16'h0000
`define OIPC_MSW_RST 10'h000
`define OIPC_OE_RST 1'b0
`define OIPC_PTR_RST 8'h00
`define OIPC_RANGE_DEF 4'h0

// bus constants
`define OIPC_DEV_ADDR 7'h60
`define OIPC_BITS_PER_BYTE 4'h8
`define OIPC_FILT_CYC 2'h2

// timing, clock in MHz and times in microseconds
`define OIPC_CLK_MHZ 40
`define OIPC_PULL_START_DELAY_US 103
`define OIPC_PULL_START_DELAY_MAX_US 140
`define OIPC_PULL_SETTLE_TIME_US 20

`endif

// file: hdl/oipc_pkg.sv
/*
 * Types of the oscillator pull-control front end: serial state machine
 * encoding and the packed state records of each module.
 * Assumes oipc_cfg.svh is on the include path.
 */
`include "oipc_cfg.svh"

package oipc_pkg;

	typedef enum logic [3:0] {
		OIPC_IDLE, OIPC_ADDR, OIPC_ADDR_ACK, OIPC_PTR, OIPC_PTR_ACK,
		OIPC_WR, OIPC_WR_ACK, OIPC_RD, OIPC_RD_MACK
	} oipc_state_t;

	typedef struct packed {
		logic scl_m, scl_s, sda_m, sda_s, scl_f, sda_f;
		logic [1:0] scl_c, sda_c;
		logic ctl_m, ctl_s, pin_m, pin_s;
		oipc_state_t st;
		logic [3:0] bitcnt;
		logic [7:0] sh, ptr, upper, rd_lo;
		logic rw, lo_next, sda_drv;
		logic [`OIPC_LSW_W-1:0] lower_frequency_word;
		logic [`OIPC_MSW_W-1:0] upper_frequency_word;
		logic oe;
		logic [`OIPC_RANGE_W-1:0] range;
		logic [15:0] dly_cnt, settle_cnt;
		logic dly_run, launch_pend, settle_run, settled, valid;
	} oipc_top_st_t;

	typedef struct packed {
		logic [`OIPC_WORD_W-1:0] hold;
		logic req_t, ack_m, ack_s;
	} oipc_src_st_t;

	typedef struct packed {
		logic [`OIPC_WORD_W-1:0] word;
		logic req_m, req_s, ack_t, oe_m, oe_s;
	} oipc_dst_st_t;

endpackage

// file: hdl/oipc_top.sv
/*
 * Serial slave front end of a digitally pulled oscillator: condition
 * detection, address and pointer decode, 16-bit register words, pull range
 * and the delayed launch of a new frequency word into the core clock.
 * Assumes scl and sda arrive unsynchronised and the core clock runs freely.
 */
// How it works
// - pull range bits 15:4 read zero, ignore writes
// - four-bit code selects one of sixteen ranges
// - range starts at factory value, bus may overwrite
// - slave only, clocks up to 1 Mbit/s
// - data changes only while clock is low
// - detect start and stop conditions
// - repeated start restarts the transaction
// - eight-bit bytes, msb first, unlimited count
// - receiver pulls data low on ninth clock
// - not-acknowledge only a foreign device address
// - after not-acknowledge keep sending next data
// - first byte is address plus direction bit
// - one-byte register pointer, registers 0 to 255
// - pointer advances per word, wraps at 255
// - words are two bytes, upper byte first
// - read starts at current pointer, zero at startup
// - pull starts within 140 us of upper word
// - frequency settles within 20 us after start
// - 26-bit word, upper part load starts change
// - output enable bit, pin control overrides it
`timescale 1ns/1ps
`include "oipc_cfg.svh"

module oipc_top #(
	parameter logic [6:0] DEV_ADDR = `OIPC_DEV_ADDR,
	parameter logic [3:0] FACTORY_RANGE = `OIPC_RANGE_DEF,
	parameter int PULL_DELAY_CYC = `OIPC_PULL_START_DELAY_US * `OIPC_CLK_MHZ,
	parameter int SETTLE_CYC = `OIPC_PULL_SETTLE_TIME_US * `OIPC_CLK_MHZ
) (
	// system clock and reset
	input wire logic clock,
	input wire logic nrst,
	// serial pins, sda open drain
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	// output enable pin control
	input wire logic oe_pin_ctl,
	input wire logic oe_pin,
	// oscillator core side
	input wire logic core_clk,
	output logic [`OIPC_WORD_W-1:0] pull_word,
	output logic out_enable,
	output logic [`OIPC_RANGE_W-1:0] pull_range,
	output logic pull_settled
);
	oipc_pkg::oipc_top_st_t q, d;
	logic scl_rise, scl_fall, start_c, stop_c, commit;
	logic [15:0] wr_word, rd_word;

	oipc_xfer_if #(.W(`OIPC_WORD_W)) xfer();

	// register read view; unmapped numbers read zero
	function automatic logic [15:0] reg_read(input oipc_pkg::oipc_top_st_t s,
		input logic [7:0] p);
		logic [15:0] v;
		v = 16'h0000;
		case (p)
			`OIPC_REG_LSW: v = s.lower_frequency_word;
			`OIPC_REG_MSW: v = {5'h00, s.oe, s.upper_frequency_word};
			`OIPC_REG_RANGE: v = {12'h000, s.range};
			default: v = 16'h0000;
		endcase
		return v;
	endfunction

	// a filtered level follows its input only after it held steady
	function automatic logic [2:0] filt_step(input logic s, input logic f,
		input logic [1:0] c);
		logic [2:0] r;
		r = {f, 2'h0};
		if (s != f) begin
			r = (c == `OIPC_FILT_CYC) ? {s, 2'h0} : {f, 2'(c + 2'h1)};
		end
		return r;
	endfunction

	assign sda_o = 1'b0; // open drain: only ever pulls low
	assign sda_oe_n = !q.sda_drv;
	assign pull_range = q.range;
	assign pull_settled = q.settled;
	assign xfer.valid = q.valid;
	assign xfer.data = {q.upper_frequency_word, q.lower_frequency_word};
	assign xfer.oe_lvl = q.ctl_s ? q.pin_s : q.oe;

	// whole front end; the pull timer runs first so a new write restarts it
	always_comb begin
		d = q;
		d.valid = 1'b0;
		commit = 1'b0;
		wr_word = {q.upper, q.sh};
		rd_word = 16'h0000;
		// two flops on each pin, then a glitch filter on scl and sda
		d.scl_m = scl_i;
		d.scl_s = q.scl_m;
		d.sda_m = sda_i;
		d.sda_s = q.sda_m;
		d.ctl_m = oe_pin_ctl;
		d.ctl_s = q.ctl_m;
		d.pin_m = oe_pin;
		d.pin_s = q.pin_m;
		{d.scl_f, d.scl_c} = filt_step(q.scl_s, q.scl_f, q.scl_c);
		{d.sda_f, d.sda_c} = filt_step(q.sda_s, q.sda_f, q.sda_c);
		scl_rise = !q.scl_f && d.scl_f;
		scl_fall = q.scl_f && !d.scl_f;
		start_c = q.scl_f && d.scl_f && q.sda_f && !d.sda_f;
		stop_c = q.scl_f && d.scl_f && !q.sda_f && d.sda_f;
		// settle window, hand-over, start delay: a relaunch restarts the window, a delay end wins
		if (q.settle_run) begin
			if (q.settle_cnt == 16'(SETTLE_CYC - 1)) begin
				d.settle_run = 1'b0;
				d.settled = 1'b1;
			end else begin
				d.settle_cnt = q.settle_cnt + 16'h0001;
			end
		end
		if (q.launch_pend && !xfer.busy) begin
			d.launch_pend = 1'b0;
			d.valid = 1'b1;
			d.settle_run = 1'b1;
			d.settle_cnt = 16'h0000;
		end
		if (q.dly_run) begin
			if (q.dly_cnt == 16'(PULL_DELAY_CYC - 1)) begin
				d.dly_run = 1'b0;
				d.launch_pend = 1'b1;
			end else begin
				d.dly_cnt = q.dly_cnt + 16'h0001;
			end
		end
		// serial protocol; the device never drives scl
		if (start_c) begin
			d.st = oipc_pkg::OIPC_ADDR;
			d.bitcnt = 4'h0;
			d.sda_drv = 1'b0;
			d.lo_next = 1'b0;
		end else if (stop_c) begin
			d.st = oipc_pkg::OIPC_IDLE;
			d.sda_drv = 1'b0;
		end else if (scl_rise) begin
			case (q.st)
				oipc_pkg::OIPC_ADDR, oipc_pkg::OIPC_PTR, oipc_pkg::OIPC_WR: begin
					d.sh = {q.sh[6:0], d.sda_f};
					d.bitcnt = q.bitcnt + 4'h1;
				end
				oipc_pkg::OIPC_RD_MACK: d.sh = {q.sh[6:0], d.sda_f};
				default: d.sh = q.sh; // nothing to sample here
			endcase
		end else if (scl_fall) begin
			// all drive changes happen just after a falling clock
			case (q.st)
				oipc_pkg::OIPC_ADDR: begin
					if (q.bitcnt == `OIPC_BITS_PER_BYTE) begin
						if (q.sh[7:1] == DEV_ADDR) begin
							d.st = oipc_pkg::OIPC_ADDR_ACK;
							d.sda_drv = 1'b1;
							d.rw = q.sh[0];
						end else begin
							d.st = oipc_pkg::OIPC_IDLE;
						end
					end
				end
				oipc_pkg::OIPC_PTR: begin
					if (q.bitcnt == `OIPC_BITS_PER_BYTE) begin
						d.st = oipc_pkg::OIPC_PTR_ACK;
						d.sda_drv = 1'b1;
					end
				end
				oipc_pkg::OIPC_WR: begin
					if (q.bitcnt == `OIPC_BITS_PER_BYTE) begin
						d.st = oipc_pkg::OIPC_WR_ACK;
						d.sda_drv = 1'b1;
						if (!q.lo_next) begin
							d.upper = q.sh;
							d.lo_next = 1'b1;
						end else begin
							commit = 1'b1;
							d.lo_next = 1'b0;
							d.ptr = q.ptr + 8'h01;
						end
					end
				end
				oipc_pkg::OIPC_ADDR_ACK: begin
					d.bitcnt = 4'h0;
					if (q.rw) begin
						rd_word = reg_read(q, q.ptr);
						d.rd_lo = rd_word[7:0];
						d.lo_next = 1'b1;
						d.sda_drv = !rd_word[15];
						d.sh = {rd_word[14:8], 1'b0};
						d.bitcnt = 4'h1;
						d.st = oipc_pkg::OIPC_RD;
					end else begin
						d.sda_drv = 1'b0;
						d.st = oipc_pkg::OIPC_PTR;
					end
				end
				oipc_pkg::OIPC_PTR_ACK: begin
					d.ptr = q.sh;
					d.sda_drv = 1'b0;
					d.bitcnt = 4'h0;
					d.lo_next = 1'b0;
					d.st = oipc_pkg::OIPC_WR;
				end
				oipc_pkg::OIPC_WR_ACK: begin
					d.sda_drv = 1'b0;
					d.bitcnt = 4'h0;
					d.st = oipc_pkg::OIPC_WR;
				end
				oipc_pkg::OIPC_RD: begin
					if (q.bitcnt == `OIPC_BITS_PER_BYTE) begin
						d.sda_drv = 1'b0;
						d.st = oipc_pkg::OIPC_RD_MACK;
					end else begin
						d.sda_drv = !q.sh[7];
						d.sh = {q.sh[6:0], 1'b0};
						d.bitcnt = q.bitcnt + 4'h1;
					end
				end
				oipc_pkg::OIPC_RD_MACK: begin
					// a nack asks for the next byte, an ack ends the read
					if (q.lo_next) begin
						rd_word = {8'h00, q.rd_lo};
						d.lo_next = 1'b0;
					end else begin
						d.ptr = q.ptr + 8'h01;
						rd_word = reg_read(q, 8'(q.ptr + 8'h01));
						d.rd_lo = rd_word[7:0];
						rd_word = {8'h00, rd_word[15:8]};
						d.lo_next = 1'b1;
					end
					d.sda_drv = !rd_word[7];
					d.sh = {rd_word[6:0], 1'b0};
					d.bitcnt = 4'h1;
					d.st = oipc_pkg::OIPC_RD;
					if (!q.sh[0]) begin
						d.sda_drv = 1'b0;
						d.st = oipc_pkg::OIPC_IDLE;
					end
				end
				default: d.st = q.st;
			endcase
		end
		// a completed word lands in its register
		if (commit) begin
			case (q.ptr)
				`OIPC_REG_LSW: d.lower_frequency_word = wr_word;
				`OIPC_REG_MSW: begin
					d.upper_frequency_word = wr_word[`OIPC_MSW_W-1:0];
					if (!q.ctl_s) begin
						d.oe = wr_word[`OIPC_OE_BIT];
					end
					d.dly_run = 1'b1;
					d.dly_cnt = 16'h0000;
					d.settled = 1'b0;
				end
				`OIPC_REG_RANGE: d.range = wr_word[`OIPC_RANGE_W-1:0];
				default: d.range = q.range;
			endcase
		end
	end

	// state register; the range comes up at its factory value
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
			q.scl_m <= 1'b1;
			q.scl_s <= 1'b1;
			q.sda_m <= 1'b1;
			q.sda_s <= 1'b1;
			q.scl_f <= 1'b1;
			q.sda_f <= 1'b1;
			q.st <= oipc_pkg::OIPC_IDLE;
			q.ptr <= `OIPC_PTR_RST;
			q.lower_frequency_word <= `OIPC_LSW_RST;
			q.upper_frequency_word <= `OIPC_MSW_RST;
			q.oe <= `OIPC_OE_RST;
			q.range <= FACTORY_RANGE;
		end else begin
			q <= d;
		end
	end

	oipc_word_xfer #(.W(`OIPC_WORD_W)) u_xfer (
		.clock(clock),
		.nrst(nrst),
		.link(xfer.dst),
		.core_clk(core_clk),
		.core_word(pull_word),
		.core_oe(out_enable)
	);

	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);

	a_reserved_zero: assert property (reg_read(q, `OIPC_REG_RANGE) < 16'h0010)
		else $error("pull range upper bits not zero");
	a_range_load: assert property (commit && q.ptr == `OIPC_REG_RANGE |=>
		q.range == $past(wr_word[3:0])) else $error("range not loaded");
	a_sda_stable: assert property ($changed(q.sda_drv) && !$past(start_c || stop_c)
		|-> !q.scl_f) else $error("sda moved while scl high");
	a_start_restarts: assert property (start_c |=> q.st == oipc_pkg::OIPC_ADDR
		&& q.bitcnt == 4'h0 && !q.sda_drv) else $error("start not taken");
	a_stop_releases: assert property (stop_c |=> q.st == oipc_pkg::OIPC_IDLE
		&& !q.sda_drv) else $error("stop not taken");
	a_nack_foreign: assert property (scl_fall && q.st == oipc_pkg::OIPC_ADDR
		&& q.bitcnt == 4'h8 && q.sh[7:1] != DEV_ADDR |=> !q.sda_drv [*2])
		else $error("foreign address acknowledged");
	a_write_ack: assert property (scl_fall && q.st == oipc_pkg::OIPC_WR
		&& q.bitcnt == 4'h8 |=> q.sda_drv && q.st == oipc_pkg::OIPC_WR_ACK)
		else $error("write byte not acknowledged");
	a_read_onward: assert property (scl_fall && q.st == oipc_pkg::OIPC_RD_MACK
		&& q.sh[0] |=> q.st == oipc_pkg::OIPC_RD && q.bitcnt == 4'h1)
		else $error("read did not continue");
	a_read_release: assert property (scl_fall && q.st == oipc_pkg::OIPC_RD_MACK
		&& !q.sh[0] |=> !q.sda_drv && q.st == oipc_pkg::OIPC_IDLE)
		else $error("acknowledged read kept driving");
	a_ptr_wrap: assert property (commit |=> q.ptr == 8'($past(q.ptr) + 8'h01))
		else $error("pointer did not advance");
	a_pull_delay: assert property (q.dly_run |-> q.dly_cnt < 16'(PULL_DELAY_CYC))
		else $error("pull start delay overrun");
	a_settle_time: assert property ($rose(q.settled) |-> $past(q.settle_run))
		else $error("settled without settle window");

	c_start_seen: cover property (start_c);
	c_read_byte: cover property (q.st == oipc_pkg::OIPC_RD_MACK);
	c_pull_launch: cover property (q.valid);
endmodule

// file: hdl/oipc_word_xfer.sv
/*
 * Toggle handshake carrying the frequency word from the system clock into
 * the oscillator core clock, and a two-flop crossing for the enable level.
 * Assumes both domains share the asynchronous active-low reset.
 */
`timescale 1ns/1ps
`include "oipc_cfg.svh"

module oipc_word_xfer #(parameter int W = `OIPC_WORD_W) (
	// system side
	input wire logic clock,
	input wire logic nrst,
	oipc_xfer_if.dst link,
	// oscillator core side
	input wire logic core_clk,
	output logic [W-1:0] core_word,
	output logic core_oe
);
	oipc_pkg::oipc_src_st_t sq, sd;
	oipc_pkg::oipc_dst_st_t dq, dd;

	// busy while the core has not echoed the last request toggle
	assign link.busy = sq.req_t != sq.ack_s;
	assign core_word = dq.word;
	assign core_oe = dq.oe_s;

	// system side: capture the word and flip the request
	always_comb begin
		sd = sq;
		sd.ack_m = dq.ack_t;
		sd.ack_s = sq.ack_m;
		if (link.valid) begin
			sd.hold = link.data;
			sd.req_t = !sq.req_t;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sq <= '0;
		end else begin
			sq <= sd;
		end
	end

	// core side: hold is stable while busy, so a multi-bit read is safe
	always_comb begin
		dd = dq;
		dd.req_m = sq.req_t;
		dd.req_s = dq.req_m;
		dd.oe_m = link.oe_lvl;
		dd.oe_s = dq.oe_m;
		if (dq.req_s != dq.ack_t) begin
			dd.word = sq.hold;
			dd.ack_t = dq.req_s;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			dq <= '0;
		end else begin
			dq <= dd;
		end
	end
endmodule

// file: hdl/oipc_xfer_if.sv
/*
 * Hand-over carrier between the serial front end and the oscillator core
 * side: a launch pulse with its frequency word and the output enable level.
 * Assumes the source side only launches while busy is low.
 */
`timescale 1ns/1ps

interface oipc_xfer_if #(parameter int W = 26);
	logic valid;
	logic [W-1:0] data;
	logic oe_lvl;
	logic busy;
	modport src(output valid, output data, output oe_lvl, input busy);
	modport dst(input valid, input data, input oe_lvl, output busy);
endinterface

// file: test/oipc_master.sv
/*
 * Serial bus master model: start, stop, byte write and byte read.
 * Assumes the bench resolves the open-drain data wire, pulled high.
 */
`timescale 1ns/1ps

module oipc_master (
	// timing reference
	input wire logic clock,
	// bus wires, sda_pull high pulls the data line low
	output logic scl,
	output logic sda_pull,
	input wire logic sda
);
	// 24 low plus 16 high clocks: one bit per microsecond at most
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask
	// data moves mid-low and stays through the high phase
	task automatic bit_out(input logic b);
		tick(12);
		sda_pull = !b;
		tick(12);
		scl = 1'b1;
		tick(16);
		scl = 1'b0;
	endtask
	// release the line, sample in the middle of the high phase
	task automatic bit_in(output logic b);
		tick(12);
		sda_pull = 1'b0;
		tick(12);
		scl = 1'b1;
		tick(8);
		b = sda;
		tick(8);
		scl = 1'b0;
	endtask
	// start and repeated start alike
	task automatic start();
		tick(12);
		sda_pull = 1'b0;
		tick(12);
		scl = 1'b1;
		tick(8);
		sda_pull = 1'b1;
		tick(8);
		scl = 1'b0;
	endtask
	task automatic stop();
		tick(12);
		sda_pull = 1'b1;
		tick(12);
		scl = 1'b1;
		tick(8);
		sda_pull = 1'b0;
		tick(8);
	endtask
	// msb first, then the ninth clock for the acknowledge
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_out(d[i]);
		bit_in(r);
		ack = !r;
	endtask
	task automatic rbyte(input logic mack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_in(r);
			d[i] = r;
		end
		bit_out(!mack);
	endtask
	// idle bus: clock high, data released
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
endmodule

// file: test/tb_oipc_top.sv
/*
 * Bench for the oscillator pull-control serial front end.
 * Assumes the master model in oipc_master.sv and shortened delay counts.
 */
`timescale 1ns/1ps
`include "oipc_cfg.svh"

module tb_oipc_top;
	localparam logic [3:0] FACT = 4'h5;
	localparam int DLY = 200;
	localparam int SETL = 40;
	localparam logic [6:0] ADR = `OIPC_DEV_ADDR;
	logic clock = 1'b0;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic oe_pin_ctl = 1'b0;
	logic oe_pin = 1'b0;
	logic scl, sda_pull, sda_o, sda_oe_n, out_enable, pull_settled, ack;
	logic [25:0] pull_word;
	logic [3:0] pull_range;
	logic [15:0] w;
	logic [7:0] b;
	wire logic sda;
	int fails = 0;
	int n_tests = 0;
	int n;

	// clocks; the core clock is offset so edges never line up
	always #12.5 clock = ~clock;
	initial #7.3 forever #62.5 core_clk = ~core_clk;
	// open drain: anyone pulling wins, otherwise pulled high
	assign sda = !sda_pull && (sda_oe_n || sda_o);

	oipc_top #(.DEV_ADDR(ADR), .FACTORY_RANGE(FACT), .PULL_DELAY_CYC(DLY),
		.SETTLE_CYC(SETL)) dut (.clock(clock), .nrst(nrst), .scl_i(scl),
		.sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .oe_pin_ctl(oe_pin_ctl),
		.oe_pin(oe_pin), .core_clk(core_clk), .pull_word(pull_word),
		.out_enable(out_enable), .pull_range(pull_range), .pull_settled(pull_settled));
	oipc_master host (.clock(clock), .scl(scl), .sda_pull(sda_pull), .sda(sda));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// start, device address with direction bit
	task automatic open(input logic rd);
		host.start();
		host.wbyte({ADR, rd}, ack);
		check(ack, 1'h1);
	endtask
	// write k words from pointer p, upper byte first
	task automatic wr(input logic [7:0] p, input logic [31:0] d, input int k);
		open(1'h0);
		host.wbyte(p, ack);
		check(ack, 1'h1);
		for (int i = k - 1; i >= 0; i--) begin
			host.wbyte(d[16*i+8+:8], ack);
			host.wbyte(d[16*i+:8], ack);
			check(ack, 1'h1);
		end
		host.stop();
	endtask
	// one word, upper byte first; a nack asks for more, an ack ends the read
	task automatic rword(output logic [15:0] v, input logic last);
		host.rbyte(1'h0, v[15:8]);
		host.rbyte(last, v[7:0]);
	endtask
	// pointer write, then repeated start into a read
	task automatic rdp(input logic [7:0] p);
		open(1'h0);
		host.wbyte(p, ack);
		open(1'h1);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// watchdog at twice the expected millisecond of traffic, 80000 clocks
	initial begin
		#2000000;
		fails++;
		finish_test();
	end

	// main sequence
	initial begin
		repeat (16) @(negedge clock);
		check(pull_range, FACT);
		check({sda_oe_n, out_enable, pull_settled}, 3'h4);
		nrst = 1'b1;
		repeat (8) @(negedge clock);
		open(1'h1);
		rword(w, 1'b0);
		check(w, 16'h0000);
		rword(w, 1'b0);
		check(w, 16'h0000);
		rword(w, 1'b1);
		check(w, {12'h000, FACT});
		host.stop();
		$display("startup read done");
		host.start();
		host.wbyte({ADR ^ 7'h01, 1'b0}, ack);
		check(ack, 1'h0);
		host.stop();
		$display("foreign address done");
		for (int c = 0; c < 16; c++) begin
			wr(8'h02, {16'h0, 12'hFFF, c[3:0]}, 1);
			check(pull_range, c[3:0]);
		end
		rdp(8'h02);
		rword(w, 1'b1);
		check(w, 16'h000F);
		host.stop();
		$display("pull range done");
		wr(8'h00, 32'hA5C3, 1);
		repeat (DLY + 100) @(negedge clock);
		check(pull_word, 26'h0);
		rdp(8'hFF);
		rword(w, 1'b0);
		check(w, 16'h0000);
		rword(w, 1'b1);
		check(w, 16'hA5C3);
		host.stop();
		$display("wrap done");
		wr(8'h00, 32'h123407FF, 2);
		check(pull_word, 26'h0);
		n = 0;
		while (pull_word === 26'h0 && n < 400) begin
			@(negedge clock);
			n++;
		end
		check(n <= DLY * 140 / 103 + 20, 1'h1);
		check(pull_word, {10'h3FF, 16'h1234});
		check(out_enable, 1'h1);
		n = 0;
		while (pull_settled !== 1'b1 && n < SETL + 40) begin
			@(negedge clock);
			n++;
		end
		check(pull_settled, 1'h1);
		$display("launch done");
		oe_pin_ctl = 1'b1;
		wr(8'h01, 32'hF800, 1);
		rdp(8'h01);
		rword(w, 1'b1);
		check(w, 16'h0400);
		host.stop();
		check(out_enable, 1'h0);
		$display("pin control done");
		rdp(8'h02);
		host.rbyte(1'h0, b);
		check(b, 8'h00);
		host.rbyte(1'h1, b);
		check(b, 8'h0F);
		host.stop();
		$display("read not-acknowledge done");
		finish_test();
	end
endmodule
